// *** hw/cpurs_core_regs.sv ***
// CPU architectural registers, system registers and status word
// Behaviour
// - Thirty-two 32-bit general-purpose registers
// - Register zero always reads zero
// - Program counter keeps low 26 bits only
// - Program counter bit 0 held zero
// - Exception or interrupt saves into numbers 0/1
// - NMI saves into numbers 2/3
// - Cause register: NMI high, exception or interrupt low half
// - Table call saves into numbers 16/17
// - Illegal-code trap saves into numbers 18/19
// - System registers by number; reserved ones ignored
// - Status bits 31 to 8 read zero
// - NMI sets bit 7, blocks nesting
// - Exception sets bits 6 and 5; bit 6 alone does not refuse interrupts
// - Bit 5 refuses maskable interrupts
// - Saturation overflow sets sticky bit 4
// - Bit 3 follows carry or borrow
// - Bit 2 follows arithmetic overflow
// - Bit 1 follows negative result
// - Bit 0 follows zero result
// - Mode pins pick 16- or 8-bit bus
// - After reset: control mode, fetch reset entry
// - Asynchronous reset first, ends power save
// - Mode pins latched at reset
`timescale 1ns/100ps
`include "cpurs_params.svh"
module cpurs_core_regs #(
    parameter int GPR_DEPTH = 32,
    parameter int GPR_WIDTH = 32
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic gpr_we,
    input wire logic [4:0] gpr_waddr,
    input wire logic [31:0] gpr_wdata,
    input wire logic [4:0] gpr_raddr_a,
    input wire logic [4:0] gpr_raddr_b,
    output logic [31:0] gpr_rdata_a,
    output logic [31:0] gpr_rdata_b,
    input wire logic pc_load,
    input wire logic [31:0] pc_next,
    output logic [31:0] program_counter,
    input wire logic flag_upd,
    input wire cpurs_pkg::cpurs_flags_s flags_in,
    input wire logic exc_req,
    input wire logic irq_req,
    input wire logic [15:0] intr_code,
    output logic irq_accept,
    output logic exc_accept,
    input wire logic nmi_req,
    input wire logic [15:0] nmi_code,
    output logic nmi_accept,
    input wire logic table_call_instr,
    input wire logic illegal_trap,
    input wire cpurs_pkg::cpurs_sr_req_s sr_req,
    output logic [31:0] sr_rdata,
    output logic sr_rvalid,
    output logic [31:0] program_status_word,
    output logic [31:0] exception_cause,
    output logic [31:0] table_call_base,
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    output logic bus_width_8,
    output logic mode_illegal,
    output logic bus_ctrl_mode,
    output logic fetch_start,
    input wire logic halt_req,
    input wire logic idle_req,
    input wire logic stop_req,
    input wire logic wake,
    output cpurs_pkg::cpurs_psave_e psave_state
);
    // ****************************************************
    // General-purpose registers
    // ****************************************************

    cpurs_gpr_file #(.DEPTH(GPR_DEPTH), .WIDTH(GPR_WIDTH), .AW(5)) u_gpr (
        .clock(clock), .rst_b(rst_b), .we(gpr_we),
        .waddr(gpr_waddr), .wdata(gpr_wdata),
        .raddr_a(gpr_raddr_a), .raddr_b(gpr_raddr_b),
        .rdata_a(gpr_rdata_a), .rdata_b(gpr_rdata_b)
    );

    // ****************************************************
    // Reset release, mode straps, power save
    // ****************************************************

    logic run_q;
    logic [1:0] mode_q;
    cpurs_pkg::cpurs_psave_e psave_q, psave_d;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            run_q <= 1'b0;
        else
            run_q <= 1'b1;
    end

    // Straps sampled while reset held; async load needs constants
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            mode_q <= {mode_select_high, mode_select_low};
    end

    assign bus_width_8 = (mode_q == `CPURS_MODE_BUS8);
    assign mode_illegal = (mode_q != `CPURS_MODE_BUS16) &&
                          (mode_q != `CPURS_MODE_BUS8);

    assign bus_ctrl_mode = 1'b1;
    assign fetch_start = !run_q && rst_b;

    always_comb
    begin
        psave_d = psave_q;
        case (psave_q)
            cpurs_pkg::CPURS_RUN:
            begin
                if (stop_req)
                    psave_d = cpurs_pkg::CPURS_STOP;
                else if (idle_req)
                    psave_d = cpurs_pkg::CPURS_IDLE;
                else if (halt_req)
                    psave_d = cpurs_pkg::CPURS_HALT;
            end
            cpurs_pkg::CPURS_HALT,
            cpurs_pkg::CPURS_IDLE,
            cpurs_pkg::CPURS_STOP:
            begin
                if (wake || nmi_req)
                    psave_d = cpurs_pkg::CPURS_RUN;
            end
            default:
                psave_d = cpurs_pkg::CPURS_RUN;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            psave_q <= cpurs_pkg::CPURS_RUN;
        else
            psave_q <= psave_d;
    end
    assign psave_state = psave_q;

    // ****************************************************
    // Program counter
    // ****************************************************

    logic [`CPURS_PC_TOP:1] pc_q;
    localparam logic [31:0] PC_RST = `CPURS_PC_RST;

    // Upper bits and carry out dropped
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            pc_q <= PC_RST[`CPURS_PC_TOP:1];
        else if (pc_load)
            pc_q <= pc_next[`CPURS_PC_TOP:1];
    end
    assign program_counter = {{`CPURS_PC_PAD_W{1'b0}}, pc_q, 1'b0};

    // ****************************************************
    // Event acceptance
    // ****************************************************

    logic [`CPURS_PSW_W-1:0] psw_q, psw_d;
    logic np, id;
    assign np = psw_q[`CPURS_PSW_NP];
    assign id = psw_q[`CPURS_PSW_ID];

    // No NMI nesting while one is serviced
    assign nmi_accept = nmi_req && !np && run_q;
    // Traps and exceptions are synchronous to the instruction stream
    assign exc_accept = exc_req && !nmi_accept && !illegal_trap;
    // Exception-in-service bit does not block here
    assign irq_accept = irq_req && !id && !np && !nmi_accept &&
                        !illegal_trap && !exc_req;

    logic save_intr, save_nmi, save_ct, save_trap;
    assign save_nmi = nmi_accept;
    assign save_trap = illegal_trap && !nmi_accept;
    assign save_intr = exc_accept || irq_accept;
    assign save_ct = table_call_instr && !nmi_accept && !illegal_trap &&
                     !save_intr;

    // ****************************************************
    // System register writes
    // ****************************************************

    logic sr_wr;
    logic [4:0] sr_num;
    logic [31:0] sr_wd;
    assign sr_wr = sr_req.wr;
    assign sr_num = sr_req.num;
    assign sr_wd = sr_req.wdata;

    logic [31:0] psw_word;
    assign psw_word = {{`CPURS_PSW_RFU_W{1'b0}}, psw_q};

    logic [31:0] intr_pc, intr_psw, nmi_pc, nmi_psw;
    logic [31:0] ct_pc, ct_psw, trap_pc, trap_psw;

    cpurs_save_pair u_intr_pair (
        .clock(clock), .rst_b(rst_b), .save(save_intr), .wdata(sr_wd),
        .cur_pc(program_counter), .cur_psw(psw_word),
        .wr_pc(sr_wr && sr_num == `CPURS_SR_INTR_PC),
        .wr_psw(sr_wr && sr_num == `CPURS_SR_INTR_PSW),
        .pc_q(intr_pc), .psw_q(intr_psw)
    );

    cpurs_save_pair u_nmi_pair (
        .clock(clock), .rst_b(rst_b), .save(save_nmi), .wdata(sr_wd),
        .cur_pc(program_counter), .cur_psw(psw_word),
        .wr_pc(sr_wr && sr_num == `CPURS_SR_NMI_PC),
        .wr_psw(sr_wr && sr_num == `CPURS_SR_NMI_PSW),
        .pc_q(nmi_pc), .psw_q(nmi_psw)
    );

    cpurs_save_pair u_ct_pair (
        .clock(clock), .rst_b(rst_b), .save(save_ct), .wdata(sr_wd),
        .cur_pc(program_counter), .cur_psw(psw_word),
        .wr_pc(sr_wr && sr_num == `CPURS_SR_CT_PC),
        .wr_psw(sr_wr && sr_num == `CPURS_SR_CT_PSW),
        .pc_q(ct_pc), .psw_q(ct_psw)
    );

    cpurs_save_pair u_trap_pair (
        .clock(clock), .rst_b(rst_b), .save(save_trap), .wdata(sr_wd),
        .cur_pc(program_counter), .cur_psw(psw_word),
        .wr_pc(sr_wr && sr_num == `CPURS_SR_TRAP_PC),
        .wr_psw(sr_wr && sr_num == `CPURS_SR_TRAP_PSW),
        .pc_q(trap_pc), .psw_q(trap_psw)
    );

    logic [15:0] nmi_cause_code, intr_cause_code;

    // Cause halves, hardware code beats software store
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            nmi_cause_code <= `CPURS_HALF_RST;
            intr_cause_code <= `CPURS_HALF_RST;
        end
        else
        begin
            if (save_nmi)
                nmi_cause_code <= nmi_code;
            else if (sr_wr && sr_num == `CPURS_SR_CAUSE)
                nmi_cause_code <= sr_wd[`CPURS_CAUSE_HI:`CPURS_CAUSE_MID];
            if (save_intr)
                intr_cause_code <= intr_code;
            else if (sr_wr && sr_num == `CPURS_SR_CAUSE)
                intr_cause_code <= sr_wd[`CPURS_CAUSE_LO:0];
        end
    end
    assign exception_cause = {nmi_cause_code, intr_cause_code};

    logic [31:0] ct_base_q;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            ct_base_q <= `CPURS_WORD_RST;
        else if (sr_wr && sr_num == `CPURS_SR_CT_BASE)
            ct_base_q <= sr_wd;
    end
    assign table_call_base = ct_base_q;

    // ****************************************************
    // Program status word
    // ****************************************************

    always_comb
    begin
        psw_d = psw_q;
        if (sr_wr && sr_num == `CPURS_SR_PSW)
            psw_d = sr_wd[`CPURS_PSW_W-1:0];
        if (flag_upd)
        begin
            psw_d[`CPURS_PSW_CY] = flags_in.carry;
            psw_d[`CPURS_PSW_OV] = flags_in.ovf;
            psw_d[`CPURS_PSW_S] = flags_in.sign;
            psw_d[`CPURS_PSW_Z] = flags_in.zero;
            if (flags_in.sat_ovf)
                psw_d[`CPURS_PSW_SAT] = 1'b1;
        end
        if (save_nmi)
            psw_d[`CPURS_PSW_NP] = 1'b1;
        if (exc_accept || save_trap)
            psw_d[`CPURS_PSW_EP] = 1'b1;
        // Every taken event except a table call masks further maskable requests
        if (save_nmi || save_intr || save_trap)
            psw_d[`CPURS_PSW_ID] = 1'b1;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            psw_q <= `CPURS_PSW_RST;
        else
            psw_q <= psw_d;
    end

    assign program_status_word = psw_word;

    // ****************************************************
    // System register reads
    // ****************************************************

    logic [31:0] sr_mux;

    // Access by number, reserved numbers read zero
    always_comb
    begin
        case (sr_num)
            `CPURS_SR_INTR_PC: sr_mux = intr_pc;
            `CPURS_SR_INTR_PSW: sr_mux = intr_psw;
            `CPURS_SR_NMI_PC: sr_mux = nmi_pc;
            `CPURS_SR_NMI_PSW: sr_mux = nmi_psw;
            `CPURS_SR_CAUSE: sr_mux = exception_cause;
            `CPURS_SR_PSW: sr_mux = psw_word;
            `CPURS_SR_CT_PC: sr_mux = ct_pc;
            `CPURS_SR_CT_PSW: sr_mux = ct_psw;
            `CPURS_SR_TRAP_PC: sr_mux = trap_pc;
            `CPURS_SR_TRAP_PSW: sr_mux = trap_psw;
            `CPURS_SR_CT_BASE: sr_mux = ct_base_q;
            default: sr_mux = `CPURS_WORD_RST;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sr_rdata <= `CPURS_WORD_RST;
            sr_rvalid <= 1'b0;
        end
        else
        begin
            sr_rvalid <= sr_req.rd;
            if (sr_req.rd)
                sr_rdata <= sr_mux;
        end
    end
endmodule // cpurs_core_regs

// *** hw/cpurs_gpr_file.sv ***
// General-purpose register memory with registered read ports
`timescale 1ns/100ps
`include "cpurs_params.svh"
module cpurs_gpr_file #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 32,
    parameter int AW = 5
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [WIDTH-1:0] rdata_a,
    output logic [WIDTH-1:0] rdata_b
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Writes to the zero register are dropped
    always_ff @(posedge clock)
    begin
        if (we && waddr != `CPURS_ZERO_REG)
            mem[waddr] <= wdata;
    end

    // Zero register never reaches storage, so its read is forced to zero
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_a <= '0;
            rdata_b <= '0;
        end
        else
        begin
            rdata_a <= (raddr_a == `CPURS_ZERO_REG) ? '0 : mem[raddr_a];
            rdata_b <= (raddr_b == `CPURS_ZERO_REG) ? '0 : mem[raddr_b];
        end
    end
endmodule // cpurs_gpr_file

// *** hw/cpurs_params.svh ***
// Constants for the CPU register set and status block
`ifndef CPURS_PARAMS_SVH
`define CPURS_PARAMS_SVH

// System register numbers
`define CPURS_SR_INTR_PC 5'h00
`define CPURS_SR_INTR_PSW 5'h01
`define CPURS_SR_NMI_PC 5'h02
`define CPURS_SR_NMI_PSW 5'h03
`define CPURS_SR_CAUSE 5'h04
`define CPURS_SR_PSW 5'h05
`define CPURS_SR_CT_PC 5'h10
`define CPURS_SR_CT_PSW 5'h11
`define CPURS_SR_TRAP_PC 5'h12
`define CPURS_SR_TRAP_PSW 5'h13
`define CPURS_SR_CT_BASE 5'h14

// Status word field positions
`define CPURS_PSW_W 8
`define CPURS_PSW_NP 7
`define CPURS_PSW_EP 6
`define CPURS_PSW_ID 5
`define CPURS_PSW_SAT 4
`define CPURS_PSW_CY 3
`define CPURS_PSW_OV 2
`define CPURS_PSW_S 1
`define CPURS_PSW_Z 0
`define CPURS_PSW_RFU_W 24

// Program counter layout
`define CPURS_PC_TOP 25
`define CPURS_PC_PAD_W 6

// Reset values
`define CPURS_PSW_RST 8'h20
`define CPURS_PC_RST 32'h0000_0000
`define CPURS_WORD_RST 32'h0000_0000
`define CPURS_HALF_RST 16'h0000

// Exception cause halves
`define CPURS_CAUSE_HI 31
`define CPURS_CAUSE_MID 16
`define CPURS_CAUSE_LO 15

// Mode pin codes {high, low}
`define CPURS_MODE_BUS16 2'b00
`define CPURS_MODE_BUS8 2'b01

// Zero register address
`define CPURS_ZERO_REG 5'h00

`endif

// *** hw/cpurs_pkg.sv ***
// Types shared by the CPU register set and status block
package cpurs_pkg;

    typedef struct packed {
        logic carry;
        logic ovf;
        logic sign;
        logic zero;
        logic sat_ovf;
    } cpurs_flags_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] num;
        logic [31:0] wdata;
    } cpurs_sr_req_s;

    typedef enum logic [1:0] {
        CPURS_RUN = 2'b00,
        CPURS_HALT = 2'b01,
        CPURS_IDLE = 2'b10,
        CPURS_STOP = 2'b11
    } cpurs_psave_e;

endpackage

// *** hw/cpurs_save_pair.sv ***
// One saved program counter and status word pair
`timescale 1ns/100ps
`include "cpurs_params.svh"
module cpurs_save_pair (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic save,
    input wire logic [31:0] cur_pc,
    input wire logic [31:0] cur_psw,
    input wire logic wr_pc,
    input wire logic wr_psw,
    input wire logic [31:0] wdata,
    output logic [31:0] pc_q,
    output logic [31:0] psw_q
);
    // Hardware save outranks a software store in the same cycle
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pc_q <= `CPURS_WORD_RST;
            psw_q <= `CPURS_WORD_RST;
        end
        else if (save)
        begin
            pc_q <= cur_pc;
            psw_q <= cur_psw;
        end
        else
        begin
            if (wr_pc)
                pc_q <= wdata;
            if (wr_psw)
                psw_q <= wdata;
        end
    end
endmodule // cpurs_save_pair

// *** verification/cpurs_core_regs_props.sv ***
// Concurrent checks on the CPU register set and status block ports
`timescale 1ns/100ps
module cpurs_core_regs_props #(
    parameter int GPR_DEPTH = 32,
    parameter int GPR_WIDTH = 32
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic pc_load,
    input wire logic [31:0] pc_next,
    input wire logic [31:0] program_counter,
    input wire logic flag_upd,
    input wire cpurs_pkg::cpurs_flags_s flags_in,
    input wire logic irq_accept,
    input wire logic exc_accept,
    input wire logic nmi_accept,
    input wire logic [15:0] intr_code,
    input wire logic [15:0] nmi_code,
    input wire cpurs_pkg::cpurs_sr_req_s sr_req,
    input wire logic sr_rvalid,
    input wire logic [31:0] sr_rdata,
    input wire logic [31:0] program_status_word,
    input wire logic [31:0] exception_cause
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // *****************************************
    // Read of a reserved number answers zero
    // *****************************************
    sequence s_rsv_rd;
        sr_req.rd && (sr_req.num inside {[5'h06:5'h0F]} || sr_req.num > 5'h14);
    endsequence
    sequence s_zero_answer;
        sr_rvalid && sr_rdata == 32'h0;
    endsequence

    a_rsv_reads_zero: assert property (s_rsv_rd |=> s_zero_answer)
        else $error("reserved system register read not zero");
    a_sr_answer: assert property (sr_req.rd |=> sr_rvalid)
        else $error("system register read not answered");
    a_pc_masked: assert property
        (pc_load |=> program_counter == ($past(pc_next) & 32'h03FF_FFFE))
        else $error("program counter load not masked");
    a_rfu_zero: assert property
        (program_status_word[31:8] == 24'h0 && program_counter[31:26] == 6'h0
        && !program_counter[0])
        else $error("fixed zero bits not zero");
    a_flags_copied: assert property
        (flag_upd |=> program_status_word[3:0] == 4'($past(flags_in) >> 1))
        else $error("condition flags not taken");
    a_sat_sticky: assert property
        (flag_upd && flags_in.sat_ovf |=> program_status_word[4])
        else $error("saturation flag not set");
    a_id_blocks: assert property
        (program_status_word[5] |-> !irq_accept)
        else $error("interrupt taken while disabled");
    a_np_blocks: assert property
        (program_status_word[7] |-> !nmi_accept && !irq_accept)
        else $error("nested request taken during nmi service");
    a_nmi_marks: assert property
        (nmi_accept |=> program_status_word[7]
        && exception_cause[31:16] == $past(nmi_code))
        else $error("nmi entry not recorded");
    a_intr_cause: assert property
        (irq_accept || exc_accept |=>
        exception_cause[15:0] == $past(intr_code))
        else $error("interrupt cause code not recorded");
    a_exc_pending: assert property
        (exc_accept |=> program_status_word[6])
        else $error("exception flag not set");
endmodule // cpurs_core_regs_props

// *** verification/cpurs_pipe_model.sv ***
// Behavioural execution pipeline issuing flag-setting additions
`timescale 1ns/100ps
module cpurs_pipe_model (
    input wire logic go,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    output logic flag_upd,
    output cpurs_pkg::cpurs_flags_s flags_in
);
    logic [32:0] sum;
    // Saturating add clamps exactly when the signed add overflows
    always_comb
    begin
        sum = {1'h0, op_a} + {1'h0, op_b};
        flag_upd = go;
        flags_in.carry = sum[32];
        flags_in.ovf = (op_a[31] == op_b[31]) && (sum[31] != op_a[31]);
        flags_in.sign = sum[31];
        flags_in.zero = (sum[31:0] == 32'h0);
        flags_in.sat_ovf = flags_in.ovf;
    end
endmodule // cpurs_pipe_model

// *** verification/testbench.sv ***
// Self-checking bench for the CPU register set and status block
`timescale 1ns/100ps
module testbench;
    logic clock = 1'h0, rst_b = 1'h0, gpr_we = 1'h0, pc_load = 1'h0;
    logic exc_req = 1'h0, irq_req = 1'h0, nmi_req = 1'h0, op_go = 1'h0;
    logic table_call_instr = 1'h0, illegal_trap = 1'h0;
    logic halt_req = 1'h0, idle_req = 1'h0, stop_req = 1'h0, wake = 1'h0;
    logic mode_select_low = 1'h1, mode_select_high = 1'h0;
    logic [4:0] gpr_waddr = '0, gpr_raddr_a = '0, gpr_raddr_b = '0;
    logic [31:0] gpr_wdata = '0, pc_next = '0, op_a = '0, op_b = '0;
    logic [15:0] intr_code = '0, nmi_code = '0;
    cpurs_pkg::cpurs_sr_req_s sr_req = '0;
    logic flag_upd, irq_accept, exc_accept, nmi_accept, sr_rvalid;
    logic bus_width_8, mode_illegal, bus_ctrl_mode, fetch_start;
    logic [31:0] gpr_rdata_a, gpr_rdata_b, program_counter, sr_rdata;
    logic [31:0] program_status_word, exception_cause, table_call_base;
    cpurs_pkg::cpurs_flags_s flags_in;
    cpurs_pkg::cpurs_psave_e psave_state;
    logic [31:0] rnd = 32'h2519;
    logic [31:0] pcv;
    logic [31:0] gm [32];
    logic [31:0] exq [$];
    logic [31:0] fa [5] = '{32'h1, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0,
        32'h8000_0000};
    logic [31:0] fb [5] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h8000_0000};
    logic [3:0] fz [5] = '{4'h0, 4'h9, 4'h6, 4'h1, 4'hD};
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;

    cpurs_core_regs DUT (.clock, .rst_b, .gpr_we, .gpr_waddr, .gpr_wdata,
        .gpr_raddr_a, .gpr_raddr_b, .gpr_rdata_a, .gpr_rdata_b, .pc_load,
        .pc_next, .program_counter, .flag_upd, .flags_in, .exc_req, .irq_req,
        .intr_code, .irq_accept, .exc_accept, .nmi_req, .nmi_code,
        .nmi_accept, .table_call_instr, .illegal_trap, .sr_req, .sr_rdata,
        .sr_rvalid, .program_status_word, .exception_cause, .table_call_base,
        .mode_select_low, .mode_select_high, .bus_width_8, .mode_illegal,
        .bus_ctrl_mode, .fetch_start, .halt_req, .idle_req, .stop_req, .wake,
        .psave_state);
    cpurs_pipe_model u_pipe (.go(op_go), .op_a, .op_b, .flag_upd, .flags_in);

    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // A quiet edge after each request: back-to-back calls never
    // assign sr_req twice in one time step
    task automatic srw(logic [4:0] num, logic [31:0] data);
        sr_req = {1'h1, 1'h0, num, data};
        tick;
        sr_req = '0;
        tick;
    endtask
    // Expected answer is queued before the request edge
    task automatic srr(logic [4:0] num, logic [31:0] exp);
        exq.push_back(exp);
        sr_req = {1'h0, 1'h1, num, 32'h0};
        tick;
        sr_req = '0;
        tick;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_fail++;
            stop_test;
        end
    end
    // Read answers stand one cycle; the falling edge sees them settled
    always @(negedge clock)
    begin
        if (sr_rvalid === 1'h1)
        begin
            if (exq.size() == 0)
                check("sr_rvalid", 32'h1, 32'h0);
            else
                check("sr_rdata", sr_rdata, exq.pop_front());
        end
    end

    // ****************
    // Scenarios
    // ****************
    initial
    begin
        repeat (5) @(posedge clock);
        #1;
        rst_b = 1'h1;
        #1;
        check("fetch_start", fetch_start, 32'h1);
        tick;
        check("fetch_start", fetch_start, 32'h0);
        check("bus_ctrl_mode", bus_ctrl_mode, 32'h1);
        check("bus_width_8", bus_width_8, 32'h1);
        check("mode_illegal", mode_illegal, 32'h0);
        check("psw", program_status_word, 32'h20);
        for (int i = 0; i < 32; i++)
        begin
            rnd = nxt(rnd);
            gm[i] = (i == 0) ? 32'h0 : rnd;
            gpr_we = 1'h1;
            gpr_waddr = 5'(i);
            gpr_wdata = rnd;
            tick;
        end
        gpr_we = 1'h0;
        for (int i = 0; i < 32; i++)
        begin
            gpr_raddr_a = 5'(i);
            gpr_raddr_b = 5'(31 - i);
            tick;
            check("gpr_a", gpr_rdata_a, gm[i]);
            check("gpr_b", gpr_rdata_b, gm[31 - i]);
        end
        for (int i = 0; i < 6; i++)
        begin
            rnd = nxt(rnd);
            pc_next = (i == 0) ? 32'hFFFF_FFFF : rnd;
            pcv = pc_next & 32'h03FF_FFFE;
            pc_load = 1'h1;
            tick;
            check("pc", program_counter, pcv);
        end
        pc_load = 1'h0;
        for (int i = 0; i < 5; i++)
        begin
            op_a = fa[i];
            op_b = fb[i];
            op_go = 1'h1;
            tick;
            check("flags", program_status_word[4:0], {i > 1, fz[i]});
        end
        op_go = 1'h0;
        srw(5'h05, 32'hFFFF_FF00);
        srr(5'h05, 32'h0);
        intr_code = 16'h00A5;
        irq_req = 1'h1;
        #1;
        check("irq_accept", irq_accept, 32'h1);
        tick;
        check("irq_accept", irq_accept, 32'h0);
        irq_req = 1'h0;
        srr(5'h00, pcv);
        srr(5'h01, 32'h0);
        srr(5'h04, 32'h0000_00A5);
        intr_code = 16'h0031;
        exc_req = 1'h1;
        #1;
        check("exc_accept", exc_accept, 32'h1);
        tick;
        exc_req = 1'h0;
        srr(5'h05, 32'h60);
        srw(5'h05, 32'h40);
        irq_req = 1'h1;
        #1;
        check("irq_accept", irq_accept, 32'h1);
        tick;
        irq_req = 1'h0;
        nmi_code = 16'h0010;
        nmi_req = 1'h1;
        #1;
        check("nmi_accept", nmi_accept, 32'h1);
        tick;
        irq_req = 1'h1;
        #1;
        check("nmi_accept", nmi_accept, 32'h0);
        check("irq_accept", irq_accept, 32'h0);
        nmi_req = 1'h0;
        irq_req = 1'h0;
        srr(5'h02, pcv);
        srr(5'h03, 32'h60);
        srr(5'h04, 32'h0010_0031);
        srr(5'h05, 32'hE0);
        table_call_instr = 1'h1;
        tick;
        table_call_instr = 1'h0;
        illegal_trap = 1'h1;
        tick;
        illegal_trap = 1'h0;
        srr(5'h10, pcv);
        srr(5'h11, 32'hE0);
        srr(5'h12, pcv);
        srr(5'h13, 32'hE0);
        rnd = nxt(rnd);
        srw(5'h14, rnd);
        check("base", table_call_base, rnd);
        srr(5'h14, rnd);
        for (int n = 6; n < 32; n++)
        begin
            if (n < 16 || n > 20)
            begin
                srw(5'(n), 32'hFFFF_FFFF);
                srr(5'(n), 32'h0);
            end
        end
        // power save entered, left on wake or reset
        idle_req = 1'h1;
        halt_req = 1'h1;
        tick;
        check("psave", psave_state, 32'h2);
        idle_req = 1'h0;
        halt_req = 1'h0;
        wake = 1'h1;
        tick;
        check("psave", psave_state, 32'h0);
        wake = 1'h0;
        stop_req = 1'h1;
        tick;
        stop_req = 1'h0;
        check("psave", psave_state, 32'h3);
        tick;
        rst_b = 1'h0;
        mode_select_high = 1'h1;
        mode_select_low = 1'h0;
        #1;
        check("psw", program_status_word, 32'h20);
        check("pc", program_counter, 32'h0);
        check("psave", psave_state, 32'h0);
        tick;
        rst_b = 1'h1;
        tick;
        tick;
        check("mode_illegal", mode_illegal, 32'h1);
        check("bus_width_8", bus_width_8, 32'h0);
        check("pending", exq.size(), 32'h0);
        stop_test;
    end
endmodule // testbench

bind cpurs_core_regs cpurs_core_regs_props #(.GPR_DEPTH(GPR_DEPTH),
    .GPR_WIDTH(GPR_WIDTH)) u_props (.clock, .rst_b, .pc_load, .pc_next,
    .program_counter, .flag_upd, .flags_in, .irq_accept, .exc_accept,
    .nmi_accept, .intr_code, .nmi_code, .sr_req, .sr_rvalid, .sr_rdata,
    .program_status_word, .exception_cause);
